// ---- include/cache_policy_pkg.sv ----
package cache_policy_pkg;
    // ****************************************
    // space identifiers
    // ****************************************
    localparam logic [7:0] ASI_LOCAL      = 8'h01;
    localparam logic [7:0] ASI_USER_INSN  = 8'h08;
    localparam logic [7:0] ASI_SUPV_INSN  = 8'h09;
    localparam logic [7:0] ASI_USER_DATA  = 8'h0a;
    localparam logic [7:0] ASI_SUPV_DATA  = 8'h0b;
    localparam logic [7:0] ASI_FLUSH_PAGE = 8'h10;
    localparam logic [7:0] ASI_FLUSH_SEG  = 8'h11;
    localparam logic [7:0] ASI_FLUSH_REG  = 8'h12;
    localparam logic [7:0] ASI_FLUSH_CTX  = 8'h13;
    localparam logic [7:0] ASI_FLUSH_USER = 8'h14;
    localparam logic [3:0] ASI_BYPASS_HI  = 4'h2;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] CONTEXT_OFS    = 8'h04;
    localparam logic [7:0] STATUS_OFS     = 8'h08;
    localparam logic [7:0] FLUSH_CNT_OFS  = 8'h0c;

    // control field positions
    localparam int CTRL_ME_BIT = 0;
    localparam int CTRL_CE_BIT = 8;
    localparam int CTRL_CL_BIT = 9;
    localparam int CTRL_CM_BIT = 10;
    localparam int CTRL_C_BIT  = 13;
    localparam int CTRL_BM_BIT = 14;

    // reset values: only boot mode set
    localparam logic [31:0] CTRL_RESET    = 32'h0000_4000;
    localparam logic [7:0]  CONTEXT_RESET = 8'h00;

    // byte write enable codes, active low, bit 0 = msb lane
    localparam logic [3:0] BWE_NONE = 4'hf;
    localparam logic [3:0] BWE_ALL  = 4'h0;

    // tag layout widths
    localparam int IDX1_W = 8;
    localparam int IDX2_W = 6;
    localparam int IDX3_W = 2;
endpackage

// ---- verilog/byte_enable_dec.sv ----
`timescale 1ns/10ps
`default_nettype none
module byte_enable_dec
    import cache_policy_pkg::*;
(
    // request
    input  wire logic [1:0] size,
    input  wire logic [1:0] va_low,
    input  wire logic       line_fill,
    // enables, active low
    output logic      [3:0] byte_we_n
);
    // size/offset decode
    always_comb begin
        byte_we_n = BWE_NONE;
        if (line_fill) begin
            byte_we_n = BWE_ALL;
        end else begin
            unique case (size)
                2'b00: byte_we_n[va_low] = 1'b0;
                2'b01: begin
                    if (va_low == 2'b00) byte_we_n = 4'b1100;
                    else if (va_low == 2'b10) byte_we_n = 4'b0011;
                end
                2'b10, 2'b11: begin
                    if (va_low == 2'b00) byte_we_n = BWE_ALL;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- verilog/flush_match.sv ----
`timescale 1ns/10ps
`default_nettype none
module flush_match
    import cache_policy_pkg::*;
#(
    parameter int CTX_W = 8
) (
    // flush request
    input  wire logic [7:0]       flush_asi,
    input  wire logic [CTX_W-1:0] cur_context,
    input  wire logic [31:12]     flush_va,
    // indexed tag entry
    input  wire logic             tag_valid,
    input  wire logic             tag_supv,
    input  wire logic [CTX_W-1:0] tag_context,
    input  wire logic [31:12]     tag_va,
    // result
    output logic                  hit
);
    logic ctx_ok;
    logic i1_ok;
    logic i2_ok;
    logic i3_ok;
    // field comparisons
    always_comb begin
        ctx_ok = tag_supv || (tag_context == cur_context);
        i1_ok  = tag_va[31:24] == flush_va[31:24];
        i2_ok  = tag_va[23:18] == flush_va[23:18];
        i3_ok  = tag_va[17:16] == flush_va[17:16];
        hit    = 1'b0;
        unique case (flush_asi)
            ASI_FLUSH_PAGE: hit = ctx_ok && i1_ok && i2_ok && i3_ok;
            ASI_FLUSH_SEG:  hit = ctx_ok && i1_ok && i2_ok;
            ASI_FLUSH_REG:  hit = ctx_ok && i1_ok;
            ASI_FLUSH_CTX:  hit = !tag_supv && (tag_context == cur_context);
            ASI_FLUSH_USER: hit = !tag_supv;
            default:        hit = 1'b0;
        endcase
        hit = hit && tag_valid;
    end
endmodule
`default_nettype wire

// ---- verilog/cache_flush_and_cacheability.sv ----
// Summary of operation
// - copy-back dirty flush: write back, invalidate
// - clean or write-through flush: invalidate only
// - one line per flush request
// - flush indexes line with va 15:5
// - no match: nothing happens
// - store-alternate flush; context from register
// - page: context/supv, index 1,2,3
// - segment: index 1,2; region: index 1
// - context: ctx plus user; user: user
// - bypass, local, unassigned spaces never cached
// - cached needs translation, cache, page enables
// - table walk, locked unaliased miss: uncached
// - bus cacheable flag on address bit
// - bus flag: zero, control bit, page bit
// - write-through atomic swap goes uncached
// - write-through atomic swap hit invalidates line
// - copy-back atomic swap cached normally
// - retry before load repeats all, else store
// - enable 0 is msb lane
// - byte store: one enable by offset
// - halfword and word enable patterns
// - misaligned: all enables off
// - line fill: all enables on
// - enables active low
`timescale 1ns/10ps
`default_nettype none
module cache_flush_and_cacheability
    import cache_policy_pkg::*;
#(
    parameter int CTX_W = 8
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // integer unit request
    input  wire logic             req_valid,
    input  wire logic             req_write,
    input  wire logic [7:0]       address_space_id,
    input  wire logic [31:0]      req_va,
    input  wire logic [1:0]       req_size,
    input  wire logic             atomic_swap_cycle,
    input  wire logic             table_walk,
    input  wire logic             page_cacheable,
    output logic                  req_done,
    // tag array, indexed by va 15:5
    output logic      [10:0]      tag_index,
    input  wire logic             tag_valid,
    input  wire logic             tag_dirty,
    input  wire logic             tag_supv,
    input  wire logic [CTX_W-1:0] tag_context,
    input  wire logic [31:12]     tag_va,
    input  wire logic             tag_alias,
    output logic                  tag_invalidate,
    // write-back of a dirty line
    output logic                  writeback_req,
    input  wire logic             writeback_done,
    // cache ram
    input  wire logic             line_fill,
    output logic      [3:0]       cache_byte_write_n,
    // system bus
    output logic                  access_cacheable,
    output logic                  muxed_addr_data_bit,
    output logic                  bus_cacheable_flag,
    output logic                  mem_req,
    output logic                  mem_store,
    input  wire logic             mem_done,
    input  wire logic             mem_retry
);
    // ****************************************
    // registers
    // ****************************************
    logic [31:0]      system_control_reg_r;
    logic [CTX_W-1:0] context_r;
    logic [15:0]      flush_cnt_r;
    logic             translation_enable;
    logic             cache_enable;
    logic             cache_lock;
    logic             copy_back;
    logic             untranslated_cacheable;
    logic             boot_mode_flag;

    assign translation_enable     = system_control_reg_r[CTRL_ME_BIT];
    assign cache_enable           = system_control_reg_r[CTRL_CE_BIT];
    assign cache_lock             = system_control_reg_r[CTRL_CL_BIT];
    assign copy_back              = system_control_reg_r[CTRL_CM_BIT];
    assign untranslated_cacheable = system_control_reg_r[CTRL_C_BIT];
    assign boot_mode_flag         = system_control_reg_r[CTRL_BM_BIT];

    typedef enum logic [2:0] {ST_IDLE, ST_FLUSH, ST_WB, ST_LOAD, ST_STORE} state_e;
    state_e state_r;

    logic apb_wr;
    logic addr_ok;
    assign apb_wr  = psel && penable && pwrite && clk_en;
    assign addr_ok = (paddr == CTRL_OFS) || (paddr == CONTEXT_OFS)
                  || (paddr == STATUS_OFS) || (paddr == FLUSH_CNT_OFS);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // control register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_control_reg_r <= CTRL_RESET;
        end else if (apb_wr && paddr == CTRL_OFS) begin
            system_control_reg_r <= pwdata & 32'h0000_6701;
        end
    end

    // context register, flush compare source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            context_r <= CONTEXT_RESET;
        end else if (apb_wr && paddr == CONTEXT_OFS) begin
            context_r <= pwdata[CTX_W-1:0];
        end
    end

    // read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            unique case (paddr)
                CTRL_OFS:      prdata <= system_control_reg_r;
                CONTEXT_OFS:   prdata <= {{(32-CTX_W){1'b0}}, context_r};
                STATUS_OFS:    prdata <= {29'h0, state_r};
                FLUSH_CNT_OFS: prdata <= {16'h0, flush_cnt_r};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // request classification
    // ****************************************
    logic is_flush;
    logic is_bypass;
    logic is_local;
    logic is_insn;
    logic is_data;
    logic flush_hit;
    logic locked_miss;
    logic cacheable_c;
    logic bus_flag_c;

    assign is_flush  = address_space_id >= ASI_FLUSH_PAGE
                    && address_space_id <= ASI_FLUSH_USER;
    assign is_bypass = address_space_id[7:4] == ASI_BYPASS_HI;
    assign is_local  = address_space_id == ASI_LOCAL;
    assign is_insn   = address_space_id == ASI_USER_INSN
                    || address_space_id == ASI_SUPV_INSN;
    assign is_data   = address_space_id == ASI_USER_DATA
                    || address_space_id == ASI_SUPV_DATA;
    assign tag_index = req_va[15:5];

    // locked cache: a tag mismatch on a valid, unaliased entry stays uncached
    assign locked_miss = cache_lock && tag_valid && !tag_alias
                      && (tag_va != req_va[31:12]);

    flush_match #(
        .CTX_W (CTX_W)
    ) u_match (
        .flush_asi   (address_space_id),
        .cur_context (context_r),
        .flush_va    (req_va[31:12]),
        .tag_valid   (tag_valid),
        .tag_supv    (tag_supv),
        .tag_context (tag_context),
        .tag_va      (tag_va),
        .hit         (flush_hit)
    );

    // cacheable decision
    always_comb begin
        cacheable_c = 1'b0;
        if (translation_enable && cache_enable && page_cacheable) begin
            if (boot_mode_flag) cacheable_c = is_data;
            else cacheable_c = is_data || is_insn;
        end
        if (table_walk || locked_miss) cacheable_c = 1'b0;
        if (atomic_swap_cycle && !copy_back) cacheable_c = 1'b0;
    end

    // bus cacheable flag
    always_comb begin
        if (is_bypass || is_local) bus_flag_c = 1'b0;
        else if (!translation_enable || table_walk
                 || (boot_mode_flag && is_insn)) bus_flag_c = untranslated_cacheable;
        else bus_flag_c = page_cacheable;
    end

    // ****************************************
    // sequencer
    // ****************************************
    logic start;
    logic swap_wt_hit;
    // the req_done cycle closes the held request, so it is not taken twice
    assign start       = clk_en && req_valid && !req_done && state_r == ST_IDLE;
    assign swap_wt_hit = atomic_swap_cycle && !copy_back && tag_valid
                      && tag_va == req_va[31:12];

    // state and bus outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r             <= ST_IDLE;
            mem_req             <= 1'b0;
            mem_store           <= 1'b0;
            writeback_req       <= 1'b0;
            tag_invalidate      <= 1'b0;
            req_done            <= 1'b0;
            access_cacheable    <= 1'b0;
            bus_flag_reg_clear: bus_cacheable_flag <= 1'b0;
        end else if (clk_en) begin
            tag_invalidate <= 1'b0;
            req_done       <= 1'b0;
            unique case (state_r)
                ST_IDLE: if (start) begin
                    access_cacheable   <= cacheable_c;
                    bus_cacheable_flag <= bus_flag_c;
                    if (is_flush && req_write) begin
                        state_r <= ST_FLUSH;
                    end else if (atomic_swap_cycle && !cacheable_c) begin
                        mem_req   <= 1'b1;
                        mem_store <= 1'b0;
                        state_r   <= ST_LOAD;
                        tag_invalidate <= swap_wt_hit;
                    end else begin
                        req_done <= 1'b1;
                    end
                end
                ST_FLUSH: begin
                    if (!flush_hit) begin
                        req_done <= 1'b1;
                        state_r  <= ST_IDLE;
                    end else if (copy_back && tag_dirty) begin
                        writeback_req <= 1'b1;
                        state_r       <= ST_WB;
                    end else begin
                        tag_invalidate <= 1'b1;
                        req_done       <= 1'b1;
                        state_r        <= ST_IDLE;
                    end
                end
                ST_WB: if (writeback_done) begin
                    writeback_req  <= 1'b0;
                    tag_invalidate <= 1'b1;
                    req_done       <= 1'b1;
                    state_r        <= ST_IDLE;
                end
                ST_LOAD: if (mem_retry) begin
                    mem_req <= 1'b1;
                end else if (mem_done) begin
                    mem_store <= 1'b1;
                    state_r   <= ST_STORE;
                end
                ST_STORE: if (mem_retry) begin
                    mem_store <= 1'b1;
                end else if (mem_done) begin
                    mem_req   <= 1'b0;
                    mem_store <= 1'b0;
                    req_done  <= 1'b1;
                    state_r   <= ST_IDLE;
                end
            endcase
        end
    end

    // flush counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_cnt_r <= 16'h0000;
        end else if (clk_en && state_r == ST_FLUSH && flush_hit) begin
            flush_cnt_r <= flush_cnt_r + 16'h0001;
        end
    end

    assign muxed_addr_data_bit = bus_cacheable_flag;

    // ****************************************
    // cache ram byte enables
    // ****************************************
    logic [3:0] bwe_c;
    byte_enable_dec u_bwe (
        .size      (req_size),
        .va_low    (req_va[1:0]),
        .line_fill (line_fill),
        .byte_we_n (bwe_c)
    );

    // registered enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cache_byte_write_n <= BWE_NONE;
        end else if (clk_en) begin
            if (line_fill || (start && req_write && !is_flush && cacheable_c))
                cache_byte_write_n <= bwe_c;
            else
                cache_byte_write_n <= BWE_NONE;
        end
    end
endmodule
`default_nettype wire

// ---- tb/cfc_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module cfc_monitor (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // watched ports
    input wire logic        line_fill,
    input wire logic [3:0]  cache_byte_write_n,
    input wire logic        req_done,
    input wire logic [7:0]  address_space_id,
    input wire logic        access_cacheable,
    input wire logic        bus_cacheable_flag,
    input wire logic        muxed_addr_data_bit,
    input wire logic        tag_invalidate,
    input wire logic        writeback_req,
    input wire logic        writeback_done,
    input wire logic [10:0] tag_index,
    input wire logic [31:0] req_va,
    input wire logic        mem_req,
    input wire logic        mem_store
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************
    // flush steps
    // ****************
    sequence s_wb_end;
        writeback_req && writeback_done;
    endsequence
    a_wb_inval: assert property (s_wb_end |-> ##[1:2] tag_invalidate)
        else $error("no invalidate after write-back");
    a_wb_held: assert property (writeback_req && !writeback_done |=> writeback_req)
        else $error("write-back request dropped early");
    a_inval_once: assert property (tag_invalidate |=> !tag_invalidate)
        else $error("invalidate longer than one cycle");
    a_index_va: assert property (tag_index == req_va[15:5])
        else $error("tag index not va 15:5");
    // ****************
    // cacheability and enables
    // ****************
    a_bypass_off: assert property (req_done && address_space_id[7:4] == 4'h2
        |-> !access_cacheable && !bus_cacheable_flag)
        else $error("bypass space cached");
    a_local_off: assert property (req_done && address_space_id == 8'h01
        |-> !access_cacheable && !bus_cacheable_flag)
        else $error("local space cached");
    a_bus_bit: assert property (muxed_addr_data_bit == bus_cacheable_flag)
        else $error("address bit differs from bus flag");
    a_fill_all: assert property (line_fill |=> cache_byte_write_n == 4'h0)
        else $error("line fill enables not all low");
    a_load_first: assert property ($rose(mem_req) |-> !mem_store)
        else $error("swap began with store");
endmodule
bind cache_flush_and_cacheability cfc_monitor u_cfc_monitor (.*);
`default_nettype wire

// ---- tb/cfc_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module cfc_mem_model #(
    parameter int DELAY = 3
) (
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // bus side of the block
    input wire logic       mem_req,
    input wire logic       mem_store,
    input wire logic       writeback_req,
    input wire logic [1:0] retry_sel,
    output logic           mem_done,
    output logic           mem_retry,
    output logic           writeback_done
);
    int   cnt;
    logic used;
    // answers after DELAY cycles, one retry per swap when asked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            used <= 1'b0;
            mem_done <= 1'b0;
            mem_retry <= 1'b0;
            writeback_done <= 1'b0;
        end else begin
            mem_done <= 1'b0;
            mem_retry <= 1'b0;
            writeback_done <= 1'b0;
            cnt <= (mem_req || writeback_req) && !mem_done && !mem_retry ? cnt + 1 : 0;
            if (!mem_req)
                used <= 1'b0;
            if (cnt == DELAY) begin
                cnt <= 0;
                if (writeback_req)
                    writeback_done <= 1'b1;
                else if (retry_sel == (mem_store ? 2'd2 : 2'd1) && !used) begin
                    mem_retry <= 1'b1;
                    used <= 1'b1;
                end else
                    mem_done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/cache_flush_and_cacheability_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module cache_flush_and_cacheability_tb import cache_policy_pkg::*; ;
    localparam logic [31:0] VA = 32'h1234_5678;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, req_valid, req_write;
    logic atomic_swap_cycle, table_walk, page_cacheable, req_done, tag_valid, tag_dirty;
    logic tag_supv, tag_alias, tag_invalidate, writeback_req, writeback_done, line_fill;
    logic access_cacheable, muxed_addr_data_bit, bus_cacheable_flag, mem_req, mem_store;
    logic mem_done, mem_retry, err, cch, flg;
    logic [7:0]  paddr, address_space_id, tag_context;
    logic [31:0] pwdata, prdata, req_va, rd;
    logic [1:0]  req_size, retry_sel;
    logic [10:0] tag_index;
    logic [31:12] tag_va, tv;
    logic [3:0]  cache_byte_write_n, bwe;
    logic [15:0] f;
    // asi, supv/ctx-miss/dirty/cm, flipped bit code, expected wb/inval
    logic [15:0] fl [15] = '{16'h1001, 16'h1033, 16'h1021, 16'h1014, 16'h10d1, 16'h1050,
        16'h1115, 16'h1118, 16'h1219, 16'h121c, 16'h131d, 16'h1390, 16'h1350, 16'h145d,
        16'h1490};
    int n_fail, compares, n_inv, n_wb, n_ld, n_st, b;
    cache_flush_and_cacheability u_cache_flush_and_cacheability (.*);
    cfc_mem_model u_cfc_mem_model (.*);
    // clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // event counters
    always @(posedge pclk) begin
        n_inv += (tag_invalidate === 1'b1);
        n_wb += (writeback_done === 1'b1);
        n_ld += ((mem_done | mem_retry) === 1'b1 && mem_store === 1'b0);
        n_st += ((mem_done | mem_retry) === 1'b1 && mem_store === 1'b1);
    end
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic run(input logic [7:0] a, input logic [31:0] v, input logic [1:0] z,
                       input logic w, s, t);
        int n;
        req_valid <= 1'b1;
        address_space_id <= a;
        req_va <= v;
        req_size <= z;
        req_write <= w;
        atomic_swap_cycle <= s;
        table_walk <= t;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (req_done !== 1'b1 && n < 300);
        `CHK("done", 1'b1, req_done)
        bwe = cache_byte_write_n;
        cch = access_cacheable;
        flg = bus_cacheable_flag;
        req_valid <= 1'b0;
        @(posedge pclk);
    endtask
    // control bits given as cm, bm, c, ce, me
    task automatic cac(input logic [7:0] a, input logic [4:0] c, input logic p, t, s,
                       input logic [1:0] e);
        apb(1, CTRL_OFS, 32'({c[3], c[2], 2'b00, c[4], 1'b0, c[1], 7'h00, c[0]}));
        page_cacheable <= p;
        run(a, 32'h0000_1000, 2'b10, 0, s, t);
        `CHK("cacheable", e[1], cch)
        `CHK("bus flag", e[0], flg)
    endtask
    function automatic logic [3:0] bwe_exp(input logic [1:0] z, o);
        if (z == 0)
            return ~(4'h1 << o);
        if (z == 1 && !o[0])
            return o[1] ? 4'h3 : 4'hc;
        return (z != 1 && o == 0) ? 4'h0 : 4'hf;
    endfunction
    // watchdog
    initial begin
        #500000;
        n_fail++;
        conclude();
    end
    // main sequence
    initial begin
        {psel, penable, pwrite, req_valid, req_write, atomic_swap_cycle, table_walk} = '0;
        {page_cacheable, tag_valid, tag_dirty, tag_supv, tag_alias, line_fill} = '0;
        {paddr, pwdata, address_space_id, req_va, req_size, tag_context, tag_va} = '0;
        retry_sel = 2'b00;
        clk_en = 1'b1;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, CTRL_OFS, 0);
        `CHK("ctrl reset", CTRL_RESET, rd)
        apb(0, CONTEXT_OFS, 0);
        `CHK("context reset", 32'(CONTEXT_RESET), rd)
        apb(0, 8'h40, 0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        cac(8'h08, 5'b00011, 1, 0, 0, 2'b11);
        cac(8'h0b, 5'b00011, 1, 0, 0, 2'b11);
        cac(8'h08, 5'b01111, 1, 0, 0, 2'b01);
        cac(8'h0a, 5'b01011, 1, 0, 0, 2'b11);
        cac(8'h24, 5'b00111, 1, 0, 0, 2'b00);
        cac(8'h01, 5'b00111, 1, 0, 0, 2'b00);
        cac(8'h0a, 5'b00110, 1, 0, 0, 2'b01);
        cac(8'h0a, 5'b00001, 1, 0, 0, 2'b01);
        cac(8'h0a, 5'b00011, 0, 0, 0, 2'b00);
        cac(8'h0a, 5'b00011, 1, 1, 0, 2'b00);
        cac(8'h0a, 5'b00011, 1, 0, 1, 2'b01);
        cac(8'h0a, 5'b10011, 1, 0, 1, 2'b11);
        // locked cache: valid mismatching entry stays uncached, a hit is cached
        apb(1, CTRL_OFS, 32'h0000_0301);
        tag_valid <= 1'b1;
        tag_va <= 20'h0000f;
        run(8'h0a, 32'h0000_1000, 2'b10, 0, 0, 0);
        `CHK("locked miss", 1'b0, cch)
        tag_va <= 20'h00001;
        run(8'h0a, 32'h0000_1000, 2'b10, 0, 0, 0);
        `CHK("locked hit", 1'b1, cch)
        tag_valid <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            run(8'h0a, 32'(k[1:0]), k[3:2], 1, 0, 0);
            `CHK("byte enables", bwe_exp(k[3:2], k[1:0]), bwe)
        end
        line_fill <= 1;
        repeat (3) @(posedge pclk);
        `CHK("fill enables", 4'h0, cache_byte_write_n)
        line_fill <= 0;
        apb(1, CONTEXT_OFS, 32'h5a);
        tag_valid <= 1;
        foreach (fl[k]) begin
            f = fl[k];
            apb(1, CTRL_OFS, 32'(f[4]) << CTRL_CM_BIT);
            tag_supv <= f[7];
            tag_context <= f[6] ? 8'h5b : 8'h5a;
            tag_dirty <= f[5];
            tv = VA[31:12];
            b = f[3:2] == 1 ? 16 : f[3:2] == 2 ? 18 : 24;
            if (f[3:2] != 0)
                tv[b] = ~tv[b];
            tag_va <= tv;
            n_inv = 0;
            n_wb = 0;
            run(f[15:8], VA, 2'b10, 1, 0, 0);
            @(posedge pclk);
            `CHK("invalidates", 32'(f[0]), n_inv)
            `CHK("write-backs", 32'(f[1]), n_wb)
        end
        // eight matching flushes, one line each
        apb(0, FLUSH_CNT_OFS, 0);
        `CHK("flush count", 32'h0000_0008, rd)
        apb(1, CTRL_OFS, 32'h0000_0101);
        {tag_supv, tag_dirty} <= 2'b00;
        tag_context <= 8'h5a;
        tag_va <= VA[31:12];
        page_cacheable <= 1;
        for (int r = 0; r < 3; r++) begin
            retry_sel <= 2'(r);
            {n_inv, n_ld, n_st} = '0;
            run(8'h0a, VA, 2'b10, 1, 1, 0);
            @(posedge pclk);
            `CHK("loads", 1 + (r == 1), n_ld)
            `CHK("stores", 1 + (r == 2), n_st)
            `CHK("swap invalidates", 1, n_inv)
        end
        conclude();
    end
endmodule
`default_nettype wire
